/* include/pma_pkg.sv */
// Package with the register map, field layout and timing constants of the PHY management block.
package pma_pkg;

    // Register offsets on the device's register port.
    localparam logic [10:0] PMA_OFS_WRVAL  = 11'h520;
    localparam logic [10:0] PMA_OFS_ADDR   = 11'h524;
    localparam logic [10:0] PMA_OFS_WRGO   = 11'h528;
    localparam logic [10:0] PMA_OFS_RDGO   = 11'h52C;
    localparam logic [10:0] PMA_OFS_RDVAL  = 11'h56C;

    // Reset values.
    localparam logic [15:0] PMA_RST_WRVAL  = 16'h0000;
    localparam logic [15:0] PMA_RST_ADDR   = 16'h0020;
    localparam logic [15:0] PMA_RST_RDVAL  = 16'h0000;
    localparam logic [15:0] PMA_ZERO16     = 16'h0000;

    // Field positions.
    localparam int PMA_GO_BIT   = 0;
    localparam int PMA_PHY_MSB  = 9;
    localparam int PMA_PHY_LSB  = 5;
    localparam int PMA_REG_MSB  = 4;
    localparam int PMA_REG_LSB  = 0;

    // Command time in microseconds and the clock rate in MHz.
    localparam int PMA_CMD_TIME_US = 82;
    localparam int PMA_CLK_MHZ     = 20;
    localparam int PMA_CMD_CYC     = PMA_CMD_TIME_US * PMA_CLK_MHZ;
    localparam int PMA_TMR_W       = 11;

    // Management frame layout.
    localparam logic [31:0] PMA_PREAMBLE  = 32'hFFFFFFFF;
    localparam logic [1:0]  PMA_SOF       = 2'h1;
    localparam logic [1:0]  PMA_OP_RD     = 2'h2;
    localparam logic [1:0]  PMA_OP_WR     = 2'h1;
    localparam logic [1:0]  PMA_TA        = 2'h2;
    localparam logic [6:0]  PMA_FRAME_END = 7'h3F;
    localparam logic [6:0]  PMA_RD_DRIVE  = 7'h2E;
    localparam logic [6:0]  PMA_DATA_FRST = 7'h30;
    localparam logic [1:0]  PMA_PH_SAMPLE = 2'h3;

    typedef enum logic [0:0] {
        PMA_IDLE = 1'b0,
        PMA_RUN  = 1'b1
    } pma_state_t;

endpackage : pma_pkg

/* design/pma_mdio_engine.sv */
// Management frame shifter running on the link clock.
module pma_mdio_engine
    import pma_pkg::*;
(
    input  wire logic        linkClk,
    input  wire logic        rst_n,
    input  wire logic        startTgl,
    input  wire logic        isRead,
    input  wire logic [4:0]  phyAddr,
    input  wire logic [4:0]  regAddr,
    input  wire logic [15:0] wrData,
    input  wire logic        mdioIn,
    output logic             doneTgl,
    output logic [15:0]      rdData,
    output logic             mdc,
    output logic             mdioOut,
    output logic             mdioOe
);

    logic        rstS1_q;
    logic        rstS2_q;
    logic        startS1_q;
    logic        startS2_q;
    logic        startS3_q;
    logic        inS1_q;
    logic        inS2_q;
    logic        busy_q;
    logic        rd_q;
    logic [1:0]  phase_q;
    logic [6:0]  bit_q;
    logic [63:0] frame_q;
    logic        startEvt;

    // Reset and start toggle come from the other clock, so both pass two flops.
    always_ff @(posedge linkClk)
    begin
        rstS1_q   <= rst_n;
        rstS2_q   <= rstS1_q;
        startS1_q <= startTgl;
        startS2_q <= startS1_q;
        startS3_q <= startS2_q;
        inS1_q    <= mdioIn;
        inS2_q    <= inS1_q;
    end

    assign startEvt = startS2_q ^ startS3_q;

    // Bit sequencer: four link clocks per management bit, 64 bits per frame.
    always_ff @(posedge linkClk)
    begin
        if (!rstS2_q)
        begin
            busy_q  <= 1'b0;
            rd_q    <= 1'b0;
            phase_q <= 2'h0;
            bit_q   <= 7'h00;
            frame_q <= 64'h0;
            doneTgl <= 1'b0;
        end
        else if (startEvt && !busy_q)
        begin
            busy_q  <= 1'b1;
            rd_q    <= isRead;
            phase_q <= 2'h0;
            bit_q   <= 7'h00;
            // Clause-22 frame; fields are read live, held steady by software.
            frame_q <= {PMA_PREAMBLE, PMA_SOF, isRead ? PMA_OP_RD : PMA_OP_WR,
                        phyAddr, regAddr, PMA_TA, wrData};
        end
        else if (busy_q)
        begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == PMA_PH_SAMPLE)
            begin
                bit_q   <= bit_q + 7'h01;
                frame_q <= {frame_q[62:0], 1'b0};
                if (bit_q == PMA_FRAME_END)
                begin
                    busy_q  <= 1'b0;
                    doneTgl <= ~doneTgl;
                end
            end
        end
    end

    // Read data is sampled mid-bit, well clear of the synchroniser delay.
    always_ff @(posedge linkClk)
    begin
        if (!rstS2_q)
            rdData <= PMA_ZERO16;
        else if (busy_q && rd_q && phase_q == PMA_PH_SAMPLE && bit_q >= PMA_DATA_FRST)
            rdData <= {rdData[14:0], inS2_q};
    end

    // Pin outputs are registered; a read frame releases the line from turnaround on.
    always_ff @(posedge linkClk)
    begin
        if (!rstS2_q)
        begin
            mdc     <= 1'b0;
            mdioOut <= 1'b1;
            mdioOe  <= 1'b0;
        end
        else
        begin
            mdc     <= busy_q & phase_q[1];
            mdioOut <= busy_q ? frame_q[63] : 1'b1;
            mdioOe  <= busy_q && (!rd_q || bit_q < PMA_RD_DRIVE);
        end
    end

    property p_frame_start;
        @(posedge linkClk) disable iff (!rstS2_q)
        (startEvt && !busy_q) |=> ##1 mdioOe && mdioOut;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame did not start driving");

endmodule : pma_mdio_engine

/* design/pma_top.sv */
// PHY management access block: command registers, busy timing and link handoff.
// Function
// - Writing 1 to write-command bit starts a PHY write; bit self-clears when done.
// - A write takes about 82 us from command to bit clearing.
// - Read-command bit 0 fetches the addressed PHY register into read data, then self-clears.
// - A read takes about 82 us before the bit clears and data is ready.
// - Read-data register holds the full 16-bit PHY value and is read-only.
// - Read-command register has only bit 0; upper bits reserved; resets to zero.
// - Write-data register holds the 16-bit value written to the PHY.
// - Address register carries PHY address in bits 9:5, reset selects PHY one.
module pma_top
    import pma_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [10:0] regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output logic [15:0]      regRdData,
    input  wire logic        linkClk,
    output logic             mdc,
    output logic             mdioOut,
    output logic             mdioOe,
    input  wire logic        mdioIn
);

    localparam int BUSY_LO = 1600;
    localparam int BUSY_HI = 1700;

    logic [15:0]          wrValue_q;
    logic [15:0]          addr_q;
    logic                 wrGo_q;
    logic                 rdGo_q;
    logic [15:0]          rdValue_q;
    pma_state_t           state_q;
    logic [PMA_TMR_W-1:0] timer_q;
    logic                 startTgl_q;
    logic                 doneS1_q;
    logic                 doneS2_q;
    logic                 doneS3_q;
    logic                 doneSeen_q;
    logic                 doneEvt;
    logic                 timerDone;
    logic                 wrCmd;
    logic                 rdCmd;
    logic                 finish;
    logic                 engDoneTgl;
    logic [15:0]          engRdData;
    logic [PMA_TMR_W-1:0] busyCnt_q;

    // Decoded command writes; a command is only taken when nothing is running.
    assign wrCmd     = regWrStb && regAddr == PMA_OFS_WRGO && regWrData[PMA_GO_BIT]
                       && state_q == PMA_IDLE;
    assign rdCmd     = regWrStb && regAddr == PMA_OFS_RDGO && regWrData[PMA_GO_BIT]
                       && state_q == PMA_IDLE && !wrCmd;
    assign timerDone = timer_q == PMA_TMR_W'(PMA_CMD_CYC - 1);
    assign finish    = state_q == PMA_RUN && timerDone && (doneSeen_q || doneEvt);
    assign doneEvt   = doneS2_q ^ doneS3_q;

    // Plain data registers; a write while busy still lands, which is why software must wait.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wrValue_q <= PMA_RST_WRVAL;
            addr_q    <= PMA_RST_ADDR;
        end
        else if (regWrStb)
        begin
            if (regAddr == PMA_OFS_WRVAL)
                wrValue_q <= regWrData;
            if (regAddr == PMA_OFS_ADDR)
                addr_q <= {6'h00, regWrData[PMA_PHY_MSB:PMA_REG_LSB]};
        end
    end

    // Command bits: set by software, cleared only by the block when the command ends.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wrGo_q <= 1'b0;
            rdGo_q <= 1'b0;
        end
        else
        begin
            if (wrCmd)
                wrGo_q <= 1'b1;
            else if (finish)
                wrGo_q <= 1'b0;
            if (rdCmd)
                rdGo_q <= 1'b1;
            else if (finish)
                rdGo_q <= 1'b0;
        end
    end

    // Busy timer holds the command bit for the full command time, even though the
    // frame itself ends sooner, so software sees the documented duration.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= PMA_IDLE;
            timer_q <= '0;
        end
        else
        begin
            case (state_q)
                PMA_IDLE:
                begin
                    timer_q <= '0;
                    if (wrCmd || rdCmd)
                        state_q <= PMA_RUN;
                end
                PMA_RUN:
                begin
                    if (!timerDone)
                        timer_q <= timer_q + PMA_TMR_W'(1);
                    if (finish)
                        state_q <= PMA_IDLE;
                end
                default:
                    state_q <= PMA_IDLE;
            endcase
        end
    end

    // Start toggle to the link domain; done toggle back through two flops plus an edge flop.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            startTgl_q <= 1'b0;
            doneS1_q   <= 1'b0;
            doneS2_q   <= 1'b0;
            doneS3_q   <= 1'b0;
            doneSeen_q <= 1'b0;
        end
        else
        begin
            if (wrCmd || rdCmd)
                startTgl_q <= ~startTgl_q;
            doneS1_q <= engDoneTgl;
            doneS2_q <= doneS1_q;
            doneS3_q <= doneS2_q;
            if (wrCmd || rdCmd)
                doneSeen_q <= 1'b0;
            else if (doneEvt)
                doneSeen_q <= 1'b1;
        end
    end

    // Read result is taken only after the done handshake, when the link word is stable.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdValue_q <= PMA_RST_RDVAL;
        else if (doneEvt && rdGo_q)
            rdValue_q <= engRdData;
    end

    // Registered read port; unmapped offsets read as zero.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            regRdData <= PMA_ZERO16;
        else if (regRdStb)
        begin
            case (regAddr)
                PMA_OFS_WRVAL: regRdData <= wrValue_q;
                PMA_OFS_ADDR:  regRdData <= addr_q;
                PMA_OFS_WRGO:  regRdData <= {15'h0000, wrGo_q};
                PMA_OFS_RDGO:  regRdData <= {15'h0000, rdGo_q};
                PMA_OFS_RDVAL: regRdData <= rdValue_q;
                default:       regRdData <= PMA_ZERO16;
            endcase
        end
    end

    // The link side; PHY and register addresses come straight from the address register.
    pma_mdio_engine u_engine (
        .linkClk (linkClk),
        .rst_n   (rst_n),
        .startTgl(startTgl_q),
        .isRead  (rdGo_q),
        .phyAddr (addr_q[PMA_PHY_MSB:PMA_PHY_LSB]),
        .regAddr (addr_q[PMA_REG_MSB:PMA_REG_LSB]),
        .wrData  (wrValue_q),
        .mdioIn  (mdioIn),
        .doneTgl (engDoneTgl),
        .rdData  (engRdData),
        .mdc     (mdc),
        .mdioOut (mdioOut),
        .mdioOe  (mdioOe)
    );

    // Helper count of how long a command bit has stood; it saturates so that a stuck
    // bit is still caught by the ceiling check instead of wrapping back into range.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            busyCnt_q <= '0;
        else if (!(wrGo_q || rdGo_q))
            busyCnt_q <= '0;
        else if (busyCnt_q != '1)
            busyCnt_q <= busyCnt_q + PMA_TMR_W'(1);
    end

    sequence s_wr_taken;
        regWrStb && regAddr == PMA_OFS_WRGO && regWrData[PMA_GO_BIT] && state_q == PMA_IDLE;
    endsequence

    sequence s_rd_taken;
        regWrStb && regAddr == PMA_OFS_RDGO && regWrData[PMA_GO_BIT] && state_q == PMA_IDLE
        && !wrCmd;
    endsequence

    property p_wr_start;
        @(posedge clk) disable iff (!rst_n)
        s_wr_taken |=> wrGo_q [*8];
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("write bit not set and held");

    property p_wr_time;
        @(posedge clk) disable iff (!rst_n)
        $fell(wrGo_q) |-> int'(busyCnt_q) >= BUSY_LO && int'(busyCnt_q) <= BUSY_HI;
    endproperty
    a_wr_time: assert property (p_wr_time) else $error("write bit time out of range");

    property p_busy_max;
        @(posedge clk) disable iff (!rst_n)
        int'(busyCnt_q) <= BUSY_HI;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("command bit stood too long");

    property p_rd_start;
        @(posedge clk) disable iff (!rst_n)
        s_rd_taken |=> rdGo_q ##1 rdGo_q;
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("read bit not set");

    property p_rd_time;
        @(posedge clk) disable iff (!rst_n)
        $fell(rdGo_q) |-> int'(busyCnt_q) >= BUSY_LO && int'(busyCnt_q) <= BUSY_HI;
    endproperty
    a_rd_time: assert property (p_rd_time) else $error("read bit time out of range");

    property p_rdval_source;
        @(posedge clk) disable iff (!rst_n)
        !$stable(rdValue_q) |-> $past(doneEvt) && $past(rdGo_q);
    endproperty
    a_rdval_source: assert property (p_rdval_source) else $error("read data changed uncaused");

    property p_rdval_ro;
        @(posedge clk) disable iff (!rst_n)
        (regWrStb && regAddr == PMA_OFS_RDVAL && !doneEvt) |=> rdValue_q == $past(rdValue_q);
    endproperty
    a_rdval_ro: assert property (p_rdval_ro) else $error("read data was written");

    property p_rdgo_bits;
        @(posedge clk) disable iff (!rst_n)
        (regRdStb && regAddr == PMA_OFS_RDGO) |=> regRdData == {15'h0000, $past(rdGo_q)};
    endproperty
    a_rdgo_bits: assert property (p_rdgo_bits) else $error("read command readback wrong");

    property p_addr_fields;
        @(posedge clk) disable iff (!rst_n)
        (regWrStb && regAddr == PMA_OFS_ADDR) |=> addr_q[9:0] == $past(regWrData[9:0])
        && addr_q[15:10] == 6'h00;
    endproperty
    a_addr_fields: assert property (p_addr_fields) else $error("address fields wrong");

    property p_one_cmd;
        @(posedge clk) disable iff (!rst_n)
        (wrGo_q || rdGo_q) |-> state_q == PMA_RUN && !(wrGo_q && rdGo_q);
    endproperty
    a_one_cmd: assert property (p_one_cmd) else $error("command bits inconsistent");

endmodule : pma_top

/* verification/pma_phy_model.sv */
// Behavioural PHY management port that answers clause-22 frames on a pulled-up line.
module pma_phy_model
(
    input  wire logic        mdc,
    input  wire logic        mdioWire,
    output logic             phyOe,
    output logic             phyOut,
    output logic [31:0]      frameSeen,
    output int               frames
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] mem [32];
    logic [15:0] dat;
    logic [13:0] hdr;
    logic        rd;
    int          ones;
    int          pos;

    // The register file starts from a known pattern so unwritten registers read predictably.
    initial
    begin
        for (int i = 0; i < 32; i++)
            mem[i] = 16'h5A00 + 16'(i);
        phyOe = 1'b0;
        phyOut = 1'b1;
        frameSeen = 32'h0000_0000;
        frames = 0;
        rd = 1'b0;
        ones = 0;
        pos = 0;
    end

    // Bits are taken on the rising clock edge; our own drive changes just after it.
    // A frame is only recognised behind at least 32 ones, so a short preamble is lost.
    always @(posedge mdc)
    begin
        if (pos == 0)
        begin
            if (mdioWire === 1'b0 && ones >= 32)
                pos = 33;
            ones = (mdioWire === 1'b1) ? ones + 1 : 0;
        end
        else
            pos = pos + 1;
        if (pos >= 33)
            frameSeen = {frameSeen[30:0], mdioWire};
        if (pos == 46)
        begin
            hdr = frameSeen[13:0];
            rd = (hdr[11:10] == 2'h2);
            dat = mem[hdr[4:0]];
        end
        if (rd && pos == 47)
            phyOe <= 1'b1;
        if (rd && pos >= 47 && pos <= 63)
            phyOut <= (pos == 47) ? 1'b0 : dat[63 - pos];
        if (pos == 64)
        begin
            if (!rd)
                mem[hdr[4:0]] = frameSeen[15:0];
            phyOe <= 1'b0;
            frames++;
            pos = 0;
            ones = 0;
            rd = 1'b0;
        end
    end
endmodule : pma_phy_model

/* verification/tb_pma_top.sv */
// Self-checking bench for the PHY management block with a PHY model on the wire.
module tb_pma_top import pma_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk;
    logic        rst_n;
    logic [10:0] regAddr;
    logic [15:0] regWrData;
    logic        regWrStb;
    logic        regRdStb;
    logic [15:0] regRdData;
    logic        linkClk;
    logic        mdc;
    logic        mdioOut;
    logic        mdioOe;
    logic        mdioWire;
    logic        phyOe;
    logic        phyOut;
    logic [31:0] frameSeen;
    int          frames;
    int          n_errors;
    int          num_checks;
    int          cycles;

    // The line has a pull-up, so it reads high when nobody drives it.
    assign mdioWire = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);

    pma_top dut_u (
        .clk       (clk),
        .rst_n     (rst_n),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regWrStb  (regWrStb),
        .regRdStb  (regRdStb),
        .regRdData (regRdData),
        .linkClk   (linkClk),
        .mdc       (mdc),
        .mdioOut   (mdioOut),
        .mdioOe    (mdioOe),
        .mdioIn    (mdioWire)
    );

    pma_phy_model phy_u (
        .mdc       (mdc),
        .mdioWire  (mdioWire),
        .phyOe     (phyOe),
        .phyOut    (phyOut),
        .frameSeen (frameSeen),
        .frames    (frames)
    );

    // System clock of 50 ns and an unrelated link clock of 160 ns.
    always #25 clk = ~clk;
    always #80 linkClk = ~linkClk;

    // A hang is cut short well beyond three commands of about 1700 cycles each.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk16

    task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk32

    task automatic chk_range(input string nm, input int lo, input int hi, input int got);
        num_checks++;
        if (got < lo || got > hi)
        begin
            n_errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask : chk_range

    task automatic reg_wr(input logic [10:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
    endtask : reg_wr

    // Read data is registered, so it is picked up half a cycle after the taking edge.
    task automatic reg_rd(input logic [10:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        @(negedge clk);
        d = regRdData;
    endtask : reg_rd

    task automatic rd_chk(input logic [10:0] a, input logic [15:0] exp, input string nm);
        logic [15:0] v;
        reg_rd(a, v);
        chk16(nm, exp, v);
    endtask : rd_chk

    // Every register access takes two edges, which sets the resolution of the timing.
    task automatic run_cmd(input logic [10:0] a, input logic [15:0] d, input bit intrude,
                           input string nm);
        logic [15:0] v;
        int          el;
        reg_wr(a, d);
        reg_rd(a, v);
        chk16("busy bit", 16'h0001, v);
        el = 2;
        if (intrude)
        begin
            reg_wr(PMA_OFS_WRGO, 16'h0001);
            el += 2;
        end
        while (v[0] !== 1'b0 && el < 3000)
        begin
            reg_rd(a, v);
            el += 2;
        end
        chk_range(nm, 1640, 1650, el);
        repeat (100) @(posedge clk);
    endtask : run_cmd

    task automatic t_reset;
        chk16("mdc idle", 16'h0000, {15'h0000, mdc});
        chk16("oe idle", 16'h0000, {15'h0000, mdioOe});
        chk16("mdio idle", 16'h0001, {15'h0000, mdioOut});
        rd_chk(PMA_OFS_WRVAL, 16'h0000, "wrval reset");
        rd_chk(PMA_OFS_ADDR, 16'h0020, "addr reset");
        rd_chk(PMA_OFS_WRGO, 16'h0000, "wrgo reset");
        rd_chk(PMA_OFS_RDGO, 16'h0000, "rdgo reset");
        rd_chk(PMA_OFS_RDVAL, 16'h0000, "rdval reset");
        rd_chk(11'h530, 16'h0000, "unmapped");
        $display("test reset done");
    endtask : t_reset

    task automatic t_write;
        reg_wr(PMA_OFS_WRVAL, 16'hA5C3);
        reg_wr(PMA_OFS_ADDR, 16'hFF6A);
        rd_chk(PMA_OFS_WRVAL, 16'hA5C3, "wrval");
        rd_chk(PMA_OFS_ADDR, 16'h036A, "addr bits");
        run_cmd(PMA_OFS_WRGO, 16'h0001, 1'b0, "write time");
        chk32("write frame", {2'h1, 2'h1, 5'h1B, 5'h0A, 2'h2, 16'hA5C3}, frameSeen);
        $display("test write done");
    endtask : t_write

    // A write command issued mid-read is refused; the read still lands whole.
    task automatic t_read;
        reg_wr(PMA_OFS_ADDR, 16'h00AA);
        run_cmd(PMA_OFS_RDGO, 16'hFFFF, 1'b1, "read time");
        chk32("read frame", {2'h1, 2'h2, 5'h05, 5'h0A, 2'h2, 16'hA5C3}, frameSeen);
        chk16("frame count", 16'h0002, 16'(frames));
        rd_chk(PMA_OFS_RDVAL, 16'hA5C3, "read value");
        rd_chk(PMA_OFS_WRGO, 16'h0000, "busy write");
        reg_wr(PMA_OFS_RDVAL, 16'h1234);
        rd_chk(PMA_OFS_RDVAL, 16'hA5C3, "read only");
        reg_wr(PMA_OFS_RDGO, 16'h0000);
        rd_chk(PMA_OFS_RDGO, 16'h0000, "zero write");
        // A wrongly started frame needs over 800 cycles to end, so wait before counting.
        repeat (1000) @(posedge clk);
        chk16("no frame", 16'h0002, 16'(frames));
        $display("test read done");
    endtask : t_read

    task automatic t_read_edge;
        reg_wr(PMA_OFS_ADDR, 16'h03FF);
        run_cmd(PMA_OFS_RDGO, 16'h0001, 1'b0, "edge time");
        chk32("edge frame", {2'h1, 2'h2, 5'h1F, 5'h1F, 2'h2, 16'h5A1F}, frameSeen);
        rd_chk(PMA_OFS_RDVAL, 16'h5A1F, "edge value");
        $display("test read edge done");
    endtask : t_read_edge

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // Reset spans four link clock edges; the link side is given time to leave it.
    initial
    begin
        clk = 1'b0;
        linkClk = 1'b0;
        rst_n = 1'b0;
        regAddr = 11'h000;
        regWrData = 16'h0000;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        n_errors = 0;
        num_checks = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (16) @(posedge clk);
        t_reset();
        t_write();
        t_read();
        t_read_edge();
        test_done();
    end
endmodule : tb_pma_top
